/* File: src/icr_pkg.sv */
package icr_pkg;

  // ----------------------------------------------------------------
  // Locations on the parallel select
  // ----------------------------------------------------------------
  localparam logic [1:0] LOC_CTRL_LOW = 2'h2;
  localparam logic [2:0] LOC_INDEX = 3'h3;
  localparam logic [2:0] LOC_DATA = 3'h7;

  // ----------------------------------------------------------------
  // Hidden register indices behind the data location
  // ----------------------------------------------------------------
  localparam logic [2:0] HID_CLK_SEL = 3'h0;
  localparam logic [2:0] HID_CLK_GATE = 3'h1;
  localparam logic [2:0] HID_SER_A_IRQ = 3'h2;
  localparam logic [2:0] HID_SER_B_IRQ = 3'h3;
  localparam logic [2:0] HID_PAR_IRQ = 3'h4;
  localparam logic [2:0] HID_MODE = 3'h5;
  localparam logic [2:0] HID_VERSION = 3'h6;
  localparam logic [2:0] HID_PARK = 3'h7;
  localparam int HID_NUM = 6;

  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic [7:0] HID_RST = 8'h00;
  localparam logic [2:0] CTRL_ONES = 3'h7;
  localparam logic [7:0] PARK_READ = 8'hFF;
  // Version code is arbitrary.
  localparam logic [7:0] VERSION_CODE = 8'h5A;

  // ----------------------------------------------------------------
  // Pin vector layout
  // ----------------------------------------------------------------
  localparam int P_DATA = 0;
  localparam int P_ADDR = 8;
  localparam int P_RD = 11;
  localparam int P_WR = 12;
  localparam int P_CS_PAR = 13;
  localparam int P_CS_A = 14;
  localparam int P_CS_B = 15;
  localparam int P_ONLINE = 16;
  localparam int P_OCCUPIED = 17;
  localparam int P_EMPTY = 18;
  localparam int P_BIDEN = 19;
  localparam int PIN_W = 20;
  localparam logic [PIN_W-1:0] PIN_RST = 20'h0F800;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_KHZ = 125000;
  localparam int OSC_SETTLE_MS = 30;
  localparam int OSC_SETTLE_CYC = OSC_SETTLE_MS * SYS_CLK_KHZ;
  localparam int COP_8_KHZ = 8000;
  localparam int COP_9_6_KHZ = 9600;
  localparam int COP_12_KHZ = 12000;
  localparam int COP_16_KHZ = 16000;
  localparam logic [4:0] COP_P8 = 5'(SYS_CLK_KHZ / COP_8_KHZ);
  localparam logic [4:0] COP_P9 = 5'(SYS_CLK_KHZ / COP_9_6_KHZ);
  localparam logic [4:0] COP_P12 = 5'(SYS_CLK_KHZ / COP_12_KHZ);
  localparam logic [4:0] COP_P16 = 5'(SYS_CLK_KHZ / COP_16_KHZ);
  localparam logic [5:0] KB_HALF = 6'h20;
  localparam logic [5:0] BUS_HALF = 6'h04;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    COP_8_33, COP_9_6_33, COP_12_33, COP_12_50,
    COP_16_33, COP_16_50, COP_LOW, COP_HIGH
  } icr_cop_rate_t;

  typedef struct packed {
    logic flow_sense;
    logic parallel_interrupt_gate;
    logic printer_choose_out;
    logic printer_init_out;
    logic auto_line_feed_out;
    logic printer_data_strobe_out;
  } icr_ctrl_t;

  typedef struct packed {
    logic test;
    logic [1:0] serial_b_clock_choice;
    logic [1:0] serial_a_clock_choice;
    logic [2:0] config_index_field;
  } icr_index_t;

  typedef struct packed {
    logic serial_b_clock_gate;
    logic serial_a_clock_gate;
    logic [1:0] spare;
    logic bus_gate;
    logic keyboard_gate;
    logic oscillator_stop;
    logic spare0;
  } icr_gate_t;

  typedef struct packed {
    logic [3:0] spare;
    logic ports_sleep_ctl;
    logic extended_interrupt_style;
    logic extended_parallel_bus;
    logic serial_queue_permit;
  } icr_mode_t;

endpackage : icr_pkg

/* File: src/icr_top.sv */
// Notes on behaviour
// [RULE1] Control readback bits 4..0 return last written values; cleared by reset.
// [RULE2] Control readback bits 7..5 read as ones; flow sense bit never read back.
// [RULE3] Control bit 4 gates the parallel interrupt: 0 off, 1 on.
// [RULE4] Hidden registers: write index at location 3, then access location 7.
// [RULE5] Index register read/write at location 3 under parallel select; resets zero.
// [RULE6] Index test bit substitutes printer inputs for the three port interrupts.
// [RULE7] Index bits 6..5 choose serial B input clock among four sources.
// [RULE8] Index bits 4..3 choose serial A input clock, same encoding.
// [RULE9] Index field 2..0 routes location 7 among hidden registers; 7 parks.
// [RULE10] Software leaves the index field at the parking value when done.
// [RULE11] Clock select bits 2..0 set coprocessor clock rate, duty or fixed level.
// [RULE12] Software writes zero to reserved clock select bits 7..3.
// [RULE13] All three selects low enters sleep; any release leaves; registers kept.
// [RULE14] Sleep stops oscillator, clocks, buses and outputs; clocks held low.
// [RULE15] Gate bits 7 and 6 stop serial B and serial A clocks.
// [RULE16] Gate bit 3 holds bus clock low; bit 2 holds keyboard clock low.
// [RULE17] Gate bit 1 stops the oscillator and freezes the three clock outputs.
// [RULE18] Oscillator clock stays blocked until the 30 ms restart has elapsed.
// [RULE19] Mode bit 3 powers ports down, clears control, disables port pins.
// [RULE20] Software sets mode bit 3 before and while port supply is off.
// [RULE21] Mode bits 2, 1, 0 select interrupt style, extended bus, serial queues.
// [RULE22] Flow sense bit with the direction pin sets bus direction in extended mode.
// [RULE23] Parking index: location 7 writes ignored, reads return a fixed value.
module icr_top #(
  parameter int OSC_SETTLE = icr_pkg::OSC_SETTLE_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Host bus pins
  input wire logic parallel_select_n_i,
  input wire logic serial_a_select_n_i,
  input wire logic serial_b_select_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // Printer pins
  input wire logic printer_online_in_i,
  input wire logic printer_occupied_in_i,
  input wire logic media_empty_in_i,
  input wire logic direction_pin_i,
  output icr_pkg::icr_ctrl_t printer_ctrl_o,
  output logic port_pins_en_o,
  output logic parallel_read_dir_o,
  // Interrupt multiplexer
  input wire logic serial_a_irq_i,
  input wire logic serial_b_irq_i,
  input wire logic parallel_irq_i,
  output logic mux_serial_a_irq_o,
  output logic mux_serial_b_irq_o,
  output logic mux_parallel_irq_o,
  output logic [7:0] serial_a_irq_route_o,
  output logic [7:0] serial_b_irq_route_o,
  output logic [7:0] parallel_irq_route_o,
  // Clocks
  output logic [1:0] serial_a_clock_choice_o,
  output logic [1:0] serial_b_clock_choice_o,
  output logic serial_a_clock_gate_o,
  output logic serial_b_clock_gate_o,
  output logic coprocessor_clock_out_o,
  output logic keyboard_clock_out_o,
  output logic bus_clock_out_o,
  output logic osc_run_o,
  output logic osc_ready_o,
  // Mode and sleep
  output icr_pkg::icr_mode_t mode_o,
  output logic sleep_o
);
  import icr_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] s1;
  logic [PIN_W-1:0] s2;
  logic [PIN_W-1:0] s3;
  logic [PIN_W-1:0] filt;
  logic [PIN_W-1:0] filt_q;

  assign pins = {direction_pin_i, media_empty_in_i, printer_occupied_in_i, printer_online_in_i,
                 serial_b_select_n_i, serial_a_select_n_i, parallel_select_n_i, wr_n_i, rd_n_i,
                 addr_i, data_i};

  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        s1[i] <= PIN_RST[i];
        s2[i] <= PIN_RST[i];
        s3[i] <= PIN_RST[i];
        filt[i] <= PIN_RST[i];
        filt_q[i] <= PIN_RST[i];
      end else begin
        s1[i] <= pins[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          filt[i] <= s3[i];
        end
        filt_q[i] <= filt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  icr_index_t index;
  icr_ctrl_t ctrl;
  logic [7:0] hid [HID_NUM];
  icr_gate_t gate;
  icr_mode_t mode;
  icr_cop_rate_t cop_rate;
  logic sleep;
  logic osc_ok;
  logic [2:0] addr_q;
  logic [7:0] data_q;
  logic wr_commit;
  logic rd_active;
  logic all_selected;

  assign addr_q = filt_q[P_ADDR+:3];
  assign data_q = filt_q[P_DATA+:8];
  assign gate = icr_gate_t'(hid[HID_CLK_GATE]);
  assign mode = icr_mode_t'(hid[HID_MODE]);
  assign cop_rate = icr_cop_rate_t'(hid[HID_CLK_SEL][2:0]);
  assign all_selected = !filt[P_CS_PAR] && !filt[P_CS_A] && !filt[P_CS_B];
  // Writes take effect when the write strobe is released.
  assign wr_commit = !filt_q[P_WR] && filt[P_WR] && !filt_q[P_CS_PAR] && !sleep;
  assign rd_active = !filt[P_RD] && !filt[P_CS_PAR] && !sleep;

  // ----------------------------------------------------------------
  // Sleep
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sleep <= 1'b0;
    end else begin
      sleep <= all_selected; // [RULE13]
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      index <= icr_index_t'(INDEX_RST);
    end else if (wr_commit && addr_q == LOC_INDEX) begin
      index <= icr_index_t'(data_q); // [RULE5]
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl <= '0;
    end else if (mode.ports_sleep_ctl) begin
      ctrl <= '0; // [RULE19]
    end else if (wr_commit && addr_q[1:0] == LOC_CTRL_LOW) begin
      ctrl <= data_q[5:0]; // [RULE1]
    end
  end

  for (genvar r = 0; r < HID_NUM; r++) begin : g_hid
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        hid[r] <= HID_RST;
      end else if (wr_commit && addr_q == LOC_DATA
                   && index.config_index_field == 3'(r)) begin
        hid[r] <= data_q; // [RULE4] [RULE9] [RULE23]
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_o <= '0;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= 1'b0;
      data_o <= '0;
      if (rd_active && addr_q == LOC_INDEX) begin
        data_oe_o <= 1'b1;
        data_o <= index; // [RULE5]
      end else if (rd_active && addr_q == LOC_DATA) begin
        data_oe_o <= 1'b1;
        unique case (index.config_index_field) // [RULE9]
          HID_VERSION: data_o <= VERSION_CODE;
          HID_PARK: data_o <= PARK_READ; // [RULE23]
          default: data_o <= hid[index.config_index_field];
        endcase
      end else if (rd_active && addr_q[1:0] == LOC_CTRL_LOW) begin
        data_oe_o <= 1'b1;
        data_o <= {CTRL_ONES, ctrl[4:0]}; // [RULE1] [RULE2]
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt multiplexer feed
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mux_serial_a_irq_o <= 1'b0;
      mux_serial_b_irq_o <= 1'b0;
      mux_parallel_irq_o <= 1'b0;
    end else if (index.test) begin
      mux_serial_b_irq_o <= filt[P_ONLINE]; // [RULE6]
      mux_serial_a_irq_o <= filt[P_OCCUPIED];
      mux_parallel_irq_o <= filt[P_EMPTY];
    end else begin
      mux_serial_b_irq_o <= serial_b_irq_i;
      mux_serial_a_irq_o <= serial_a_irq_i;
      mux_parallel_irq_o <= parallel_irq_i && ctrl.parallel_interrupt_gate; // [RULE3]
    end
  end

  assign serial_a_irq_route_o = hid[HID_SER_A_IRQ];
  assign serial_b_irq_route_o = hid[HID_SER_B_IRQ];
  assign parallel_irq_route_o = hid[HID_PAR_IRQ];
  assign mode_o = mode; // [RULE21]
  assign serial_a_clock_choice_o = index.serial_a_clock_choice; // [RULE8]
  assign serial_b_clock_choice_o = index.serial_b_clock_choice; // [RULE7]
  assign serial_a_clock_gate_o = gate.serial_a_clock_gate; // [RULE15]
  assign serial_b_clock_gate_o = gate.serial_b_clock_gate; // [RULE15]

  // ----------------------------------------------------------------
  // Port pins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      printer_ctrl_o <= '0;
      port_pins_en_o <= 1'b0;
      parallel_read_dir_o <= 1'b0;
      sleep_o <= 1'b0;
    end else begin
      printer_ctrl_o <= ctrl;
      port_pins_en_o <= !mode.ports_sleep_ctl && !sleep; // [RULE19] [RULE14]
      sleep_o <= sleep;
      if (mode.extended_parallel_bus) begin
        parallel_read_dir_o <= filt[P_BIDEN] && ctrl.flow_sense; // [RULE22]
      end else begin
        parallel_read_dir_o <= filt[P_BIDEN];
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator restart
  // ----------------------------------------------------------------
  logic [21:0] osc_cnt;
  logic osc_en;

  assign osc_en = !gate.oscillator_stop && !sleep;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_cnt <= '0;
      osc_ok <= 1'b0;
      osc_run_o <= 1'b0;
    end else begin
      osc_run_o <= osc_en; // [RULE17] [RULE14]
      if (!osc_en) begin
        osc_cnt <= '0;
        osc_ok <= 1'b0;
      end else if (!osc_ok) begin
        osc_cnt <= osc_cnt + 22'h1;
        osc_ok <= osc_cnt == 22'(OSC_SETTLE - 1); // [RULE18]
      end
    end
  end

  assign osc_ready_o = osc_ok;

  // ----------------------------------------------------------------
  // Coprocessor clock
  // ----------------------------------------------------------------
  logic [4:0] cop_cnt;
  logic [4:0] cop_period;
  logic [4:0] cop_high;

  always_comb begin
    unique case (cop_rate) // [RULE11]
      COP_8_33: cop_period = COP_P8;
      COP_9_6_33: cop_period = COP_P9;
      COP_12_33, COP_12_50: cop_period = COP_P12;
      COP_16_33, COP_16_50, COP_LOW, COP_HIGH: cop_period = COP_P16;
    endcase
    if (cop_rate == COP_12_50 || cop_rate == COP_16_50) begin
      cop_high = cop_period >> 1;
    end else begin
      cop_high = 5'(cop_period / 5'h3);
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cop_cnt <= '0;
      coprocessor_clock_out_o <= 1'b0;
    end else if (sleep) begin
      cop_cnt <= '0;
      coprocessor_clock_out_o <= 1'b0; // [RULE14]
    end else if (osc_ok) begin
      cop_cnt <= (cop_cnt >= cop_period - 5'h1) ? 5'h0 : cop_cnt + 5'h1;
      if (cop_rate == COP_LOW) begin
        coprocessor_clock_out_o <= 1'b0; // [RULE11]
      end else if (cop_rate == COP_HIGH) begin
        coprocessor_clock_out_o <= 1'b1;
      end else begin
        coprocessor_clock_out_o <= cop_cnt < cop_high;
      end
    end
  end

  // ----------------------------------------------------------------
  // Keyboard and bus clocks
  // ----------------------------------------------------------------
  logic [5:0] kb_cnt;
  logic [5:0] bus_cnt;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      kb_cnt <= '0;
      keyboard_clock_out_o <= 1'b0;
    end else if (sleep || gate.keyboard_gate) begin
      kb_cnt <= '0;
      keyboard_clock_out_o <= 1'b0; // [RULE16] [RULE14]
    end else if (osc_ok) begin // [RULE17]
      kb_cnt <= (kb_cnt == KB_HALF - 6'h1) ? 6'h0 : kb_cnt + 6'h1;
      if (kb_cnt == KB_HALF - 6'h1) begin
        keyboard_clock_out_o <= !keyboard_clock_out_o;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus_cnt <= '0;
      bus_clock_out_o <= 1'b0;
    end else if (sleep || gate.bus_gate) begin
      bus_cnt <= '0;
      bus_clock_out_o <= 1'b0; // [RULE16] [RULE14]
    end else if (osc_ok) begin // [RULE17]
      bus_cnt <= (bus_cnt == BUS_HALF - 6'h1) ? 6'h0 : bus_cnt + 6'h1;
      if (bus_cnt == BUS_HALF - 6'h1) begin
        bus_clock_out_o <= !bus_clock_out_o;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  ctrl_write_a: assert property (wr_commit && addr_q[1:0] == LOC_CTRL_LOW  // [RULE1]
      && !mode.ports_sleep_ctl |=> ctrl[4:0] == $past(data_q[4:0]))
    else $error("Control bits not stored.");
  ctrl_ones_a: assert property (rd_active && addr_q == 3'h2 |=>  // [RULE2]
      data_oe_o && data_o[7:5] == 3'h7 && data_o[4:0] == $past(ctrl[4:0]))
    else $error("Control readback wrong.");
  irq_gate_a: assert property (!index.test && !ctrl.parallel_interrupt_gate  // [RULE3]
      |=> !mux_parallel_irq_o)
    else $error("Parallel interrupt passed while gated.");
  index_write_a: assert property (wr_commit && addr_q == LOC_INDEX  // [RULE5]
      |=> index == $past(data_q))
    else $error("Index not stored.");
  test_sub_a: assert property (index.test |=>  // [RULE6]
      mux_serial_b_irq_o == $past(filt[P_ONLINE]) && mux_parallel_irq_o == $past(filt[P_EMPTY]))
    else $error("Test substitution wrong.");
  park_hold_a: assert property (index.config_index_field == HID_PARK  // [RULE23]
      && !(wr_commit && addr_q == LOC_INDEX) |=> $stable(hid[HID_MODE]) && $stable(hid[0]))
    else $error("Parked write changed a register.");
  sleep_entry_a: assert property (all_selected |=> sleep ##1 sleep_o && !port_pins_en_o)  // [RULE13]
    else $error("Sleep not entered.");
  sleep_clocks_a: assert property (sleep |=> !coprocessor_clock_out_o  // [RULE14]
      && !keyboard_clock_out_o && !bus_clock_out_o)
    else $error("Clock running in sleep.");
  bus_low_a: assert property (gate.bus_gate |=> !bus_clock_out_o)  // [RULE16]
    else $error("Bus clock not held low.");
  osc_block_a: assert property ($rose(osc_en) |-> !osc_ok [*2])  // [RULE18]
    else $error("Oscillator clock released early.");
  port_down_a: assert property (mode.ports_sleep_ctl |=> ctrl == '0 && !port_pins_en_o)  // [RULE19]
    else $error("Power-down did not clear control.");

  data_write_c: cover property (wr_commit && addr_q == LOC_DATA);
  sleep_c: cover property ($fell(sleep));
  osc_ready_c: cover property ($rose(osc_ok));
  test_mode_c: cover property (index.test && mux_serial_a_irq_o);

endmodule : icr_top

/* File: verification/icr_host_model.sv */
module icr_host_model (
  // Bus clock
  input wire logic clk_i,
  // Host bus pins
  output logic sel_par_n_o,
  output logic sel_a_n_o,
  output logic sel_b_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [2:0] addr_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {sel_par_n_o, sel_a_n_o, sel_b_n_o, rd_n_o, wr_n_o} = 5'h1F;
    addr_o = 3'h0;
    data_o = 8'h00;
  end

  // ----------------------------------------------------------------
  // Byte access with address and data held around the strobe.
  // ----------------------------------------------------------------
  task automatic access(input logic is_wr, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sel_par_n_o <= 1'b0;
    addr_o <= a;
    data_o <= d;
    repeat (5) @(posedge clk_i);
    wr_n_o <= ~is_wr;
    rd_n_o <= is_wr;
    repeat (8) @(posedge clk_i);
    wr_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    sel_par_n_o <= 1'b1;
    addr_o <= ~a;
    data_o <= ~d;
  endtask : access

  // ----------------------------------------------------------------
  // All three selects together.
  // ----------------------------------------------------------------
  task automatic sleep(input logic on);
    @(posedge clk_i);
    sel_par_n_o <= ~on;
    sel_a_n_o <= ~on;
    sel_b_n_o <= ~on;
  endtask : sleep
endmodule : icr_host_model

/* File: verification/indirect_config_clock_regs_tb.sv */
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t: got %0h expected %0h", $time, g, e); end end

module indirect_config_clock_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import icr_pkg::*;
  localparam logic [7:0] MASK [6] = '{8'h07, 8'hCE, 8'h0F, 8'h0F, 8'h0F, 8'h07};
  localparam int PER [8] = '{15, 13, 10, 10, 7, 7, 7, 7};
  localparam int HI [8] = '{5, 4, 3, 5, 2, 3, 0, 7};
  logic sys_clk_i, sys_rst_i, sel_par_n, sel_a_n, sel_b_n, rd_n, wr_n;
  logic [2:0] addr;
  logic [7:0] wdata, data_o, r, route_a, route_b, route_p;
  logic data_oe_o, oe_q = 1'b0, bus_q = 1'b0;
  logic online, occupied, empty, dir_pin, irq_a, irq_b, irq_p;
  logic pins_en, rd_dir, mux_a, mux_b, mux_p, gate_a, gate_b;
  logic cop, kb, bus, osc_run, osc_rdy, sleep_st;
  logic [1:0] ch_a, ch_b;
  icr_ctrl_t pctrl;
  icr_mode_t mode;
  logic [15:0] n_cop = 16'h0, n_bus = 16'h0, n_kb = 16'h0, n_tgl = 16'h0;
  logic [15:0] d_cop, d_bus, d_kb, d_tgl;
  logic [31:0] seed = 32'h9773E54D;
  logic [7:0] exp_q [$];
  logic [7:0] exp_v;
  logic [7:0] vals [6];
  int n_fail = 0;
  int total_checks = 0;

  icr_top #(.OSC_SETTLE(20)) i_icr_top (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .parallel_select_n_i(sel_par_n),
    .serial_a_select_n_i(sel_a_n), .serial_b_select_n_i(sel_b_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .addr_i(addr), .data_i(wdata), .data_o(data_o), .data_oe_o(data_oe_o),
    .printer_online_in_i(online), .printer_occupied_in_i(occupied), .media_empty_in_i(empty),
    .direction_pin_i(dir_pin), .printer_ctrl_o(pctrl), .port_pins_en_o(pins_en),
    .parallel_read_dir_o(rd_dir), .serial_a_irq_i(irq_a), .serial_b_irq_i(irq_b),
    .parallel_irq_i(irq_p), .mux_serial_a_irq_o(mux_a), .mux_serial_b_irq_o(mux_b),
    .mux_parallel_irq_o(mux_p), .serial_a_irq_route_o(route_a),
    .serial_b_irq_route_o(route_b), .parallel_irq_route_o(route_p),
    .serial_a_clock_choice_o(ch_a), .serial_b_clock_choice_o(ch_b),
    .serial_a_clock_gate_o(gate_a), .serial_b_clock_gate_o(gate_b),
    .coprocessor_clock_out_o(cop), .keyboard_clock_out_o(kb), .bus_clock_out_o(bus),
    .osc_run_o(osc_run), .osc_ready_o(osc_rdy), .mode_o(mode), .sleep_o(sleep_st)
  );

  icr_host_model i_icr_host_model (
    .clk_i(sys_clk_i), .sel_par_n_o(sel_par_n), .sel_a_n_o(sel_a_n), .sel_b_n_o(sel_b_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .data_o(wdata)
  );

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed[7:0];
  endfunction : rnd

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_icr_host_model.access(1'b1, a, d);
    repeat (2) @(posedge sys_clk_i);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_icr_host_model.access(1'b0, a, rnd());
  endtask : rd

  task automatic sample(input int w);
    logic [15:0] s0, s1, s2, s3;
    s0 = n_cop;
    s1 = n_bus;
    s2 = n_kb;
    s3 = n_tgl;
    repeat (w) @(posedge sys_clk_i);
    d_cop = n_cop - s0;
    d_bus = n_bus - s1;
    d_kb = n_kb - s2;
    d_tgl = n_tgl - s3;
  endtask : sample

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Clock, monitor and watchdog.
  // ----------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    oe_q <= data_oe_o;
    bus_q <= bus;
    n_cop <= n_cop + 16'(cop);
    n_bus <= n_bus + 16'(bus);
    n_kb <= n_kb + 16'(kb);
    n_tgl <= n_tgl + 16'(bus ^ bus_q);
    if (data_oe_o === 1'b1 && oe_q !== 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        exp_v = exp_q.pop_front();
        `CHK(data_o, exp_v)
      end
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    {online, occupied, empty, dir_pin, irq_a, irq_b, irq_p} = 7'h00;
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(3'h3, INDEX_RST);
    rd(3'h2, 8'hE0);
    r = rnd();
    wr(3'h2, r);
    rd(3'h2, {CTRL_ONES, r[4:0]});
    `CHK(pctrl, r[5:0])
    for (int i = 0; i < HID_NUM; i++) begin
      r = rnd();
      wr(LOC_INDEX, {1'b0, r[6:3], 3'(i)});
      `CHK({ch_b, ch_a}, r[6:3])
      vals[i] = rnd() & MASK[i];
      wr(LOC_DATA, vals[i]);
      rd(LOC_DATA, vals[i]);
    end
    `CHK({route_a, route_b, route_p, mode}, {vals[2], vals[3], vals[4], vals[5]})
    wr(LOC_INDEX, {5'h00, HID_VERSION});
    rd(LOC_DATA, VERSION_CODE);
    wr(LOC_INDEX, {5'h00, HID_PARK});
    wr(LOC_DATA, rnd());
    rd(LOC_DATA, PARK_READ);
    wr(LOC_INDEX, {5'h00, HID_MODE});
    rd(LOC_DATA, vals[5]);
    wr(LOC_DATA, 8'h02);
    dir_pin <= 1'b1;
    wr(3'h2, 8'h3F);
    `CHK({rd_dir, mode}, 9'h102)
    wr(3'h2, 8'h1F);
    `CHK(rd_dir, 1'b0)
    wr(LOC_DATA, 8'h08);
    rd(3'h2, 8'hE0);
    `CHK(pins_en, 1'b0)
    rd(LOC_INDEX, {5'h00, HID_MODE});
    wr(LOC_DATA, 8'h00);
    `CHK(pins_en, 1'b1)
    {irq_a, irq_b, irq_p} <= 3'b101;
    {online, occupied, empty} <= 3'b100;
    wr(3'h2, 8'h10);
    `CHK({mux_a, mux_b, mux_p}, 3'b101)
    wr(3'h2, 8'h00);
    `CHK(mux_p, 1'b0)
    wr(LOC_INDEX, 8'h87);
    `CHK({mux_a, mux_b, mux_p}, 3'b010)
    wr(LOC_INDEX, {5'h00, HID_CLK_GATE});
    wr(LOC_DATA, 8'hCC);
    sample(128);
    `CHK({gate_b, gate_a, d_bus, d_kb}, {2'b11, 32'h0})
    wr(LOC_DATA, 8'h02);
    sample(128);
    `CHK({osc_run, d_tgl}, 17'h0)
    wr(LOC_DATA, 8'h00);
    `CHK(osc_rdy, 1'b0)
    repeat (30) @(posedge sys_clk_i);
    sample(128);
    `CHK({osc_rdy, gate_b, gate_a, d_bus, d_kb}, {3'b100, 16'd64, 16'd64})
    wr(LOC_INDEX, {5'h00, HID_CLK_SEL});
    for (int c = 0; c < 8; c++) begin
      wr(LOC_DATA, 8'(c));
      repeat (16) @(posedge sys_clk_i);
      sample(8 * PER[c]);
      `CHK(d_cop, 16'(8 * HI[c]))
    end
    i_icr_host_model.sleep(1'b1);
    repeat (8) @(posedge sys_clk_i);
    sample(64);
    `CHK({sleep_st, pins_en, cop, kb, bus, d_cop, d_kb, d_bus}, {2'b10, 51'h0})
    i_icr_host_model.sleep(1'b0);
    repeat (8) @(posedge sys_clk_i);
    `CHK(sleep_st, 1'b0)
    rd(LOC_DATA, 8'h07);
    wr(LOC_INDEX, {5'h00, HID_PARK});
    `CHK(exp_q.size(), 0)
    test_done();
  end
endmodule : indirect_config_clock_regs_tb
